//--- src/wdtr_watchdog.v
`timescale 1ns/1ns
`include "wdtr_consts.vh"
module wdtr_watchdog (
  input  wire       clock_i,
  input  wire       resetn_i,
  input  wire       enable_i,
  input  wire       restart_i,
  input  wire       int_enable_i,
  input  wire [1:0] timeout_select_i,
  output reg        timeout_irq_o,
  output reg        timeout_flag_o,
  output reg        window_active_o,
  output reg        sys_reset_o
);

  // ----------------------------------------------------------------
  // State codes
  // ----------------------------------------------------------------
  localparam [2:0] ST_OFF = 3'h1;
  localparam [2:0] ST_RUN = 3'h2;
  localparam [2:0] ST_WIN = 3'h4;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [2:0]             state_ff;
  reg  [2:0]             nxt_state;
  reg  [`WDTR_CNT_W-1:0] count_ff;
  reg  [`WDTR_CNT_W-1:0] nxt_count;
  reg  [1:0]             sel_ff;
  reg  [1:0]             nxt_sel;
  reg                    nxt_irq;
  reg                    nxt_flag;
  reg                    nxt_win;
  reg                    nxt_rst;
  wire                   hit;
  wire                   clear;
  wire                   in_run;
  wire                   in_win;
  wire                   win_end;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Every interval is a multiple of 1024 clocks, so the low bits of
  // the one shared counter run 0..511 across the reset window.
  function win_last;
    input [`WDTR_CNT_W-1:0] c;
    begin
      win_last = (c[`WDTR_WIN_W-1:0] == `WDTR_RST_WIN - 10'h001);
    end
  endfunction

  // ----------------------------------------------------------------
  // Timeout tap
  // ----------------------------------------------------------------
  // Select changes only take effect at restart, so a mid-interval
  // change cannot skip past the tap and hang the watchdog.
  wdtr_tap wdtr_tap_i (
    .count_i          (count_ff),
    .timeout_select_i (sel_ff),
    .hit_o            (hit)
  );

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  // Disable behaves as a held restart
  assign clear   = !enable_i || restart_i;
  assign in_run  = (state_ff == ST_RUN);
  assign in_win  = (state_ff == ST_WIN);
  assign win_end = in_win && win_last(count_ff);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;
    if (!enable_i) begin
      nxt_state = ST_OFF;
    end else if (restart_i) begin
      nxt_state = ST_RUN;
    end else begin
      case (state_ff)
        ST_OFF: begin
          nxt_state = ST_RUN;
        end
        ST_RUN: begin
          if (hit) begin
            nxt_state = ST_WIN;
          end
        end
        ST_WIN: begin
          if (win_last(count_ff)) begin
            nxt_state = ST_RUN;
          end
        end
        default: begin
          nxt_state = ST_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always @* begin
    nxt_count = count_ff + 25'h0000001;
    if (clear || win_end) begin
      // Self-restart after a reset pulse; the chip reset is external
      nxt_count = `WDTR_CNT_RST;
    end
  end

  // ----------------------------------------------------------------
  // Select
  // ----------------------------------------------------------------
  always @* begin
    nxt_sel = sel_ff;
    if (clear) begin
      nxt_sel = timeout_select_i;
    end
  end

  // ----------------------------------------------------------------
  // Output next values
  // ----------------------------------------------------------------
  always @* begin
    nxt_irq = 1'b0;
    if (!clear && in_run && hit) begin
      nxt_irq = int_enable_i;
    end
  end

  always @* begin
    nxt_flag = timeout_flag_o;
    if (clear || win_end) begin
      nxt_flag = 1'b0;
    end else if (in_run && hit) begin
      nxt_flag = 1'b1;
    end
  end

  always @* begin
    nxt_rst = 1'b0;
    if (!clear && win_end) begin
      nxt_rst = 1'b1;
    end
  end

  always @* begin
    nxt_win = (nxt_state == ST_WIN);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= ST_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_ff <= `WDTR_CNT_RST;
    end else begin
      count_ff <= nxt_count;
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sel_ff <= `WDTR_SEL_RST;
    end else begin
      sel_ff <= nxt_sel;
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timeout_irq_o <= 1'b0;
    end else begin
      timeout_irq_o <= nxt_irq;
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timeout_flag_o <= 1'b0;
    end else begin
      timeout_flag_o <= nxt_flag;
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      window_active_o <= 1'b0;
    end else begin
      window_active_o <= nxt_win;
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sys_reset_o <= 1'b0;
    end else begin
      sys_reset_o <= nxt_rst;
    end
  end

endmodule // wdtr_watchdog

//--- include/wdtr_consts.vh
`ifndef WDTR_CONSTS_VH
`define WDTR_CONSTS_VH
// ----------------------------------------------------------------
// Counter geometry
// ----------------------------------------------------------------
`define WDTR_CNT_W        25
`define WDTR_CNT_RST      25'h0000000
// Timeout exponents per select code
`define WDTR_EXP_SEL0     15
`define WDTR_EXP_SEL1     18
`define WDTR_EXP_SEL2     21
`define WDTR_EXP_SEL3     24
// Reset window after interrupt timeout, system clocks
`define WDTR_RST_WIN      10'h200
`define WDTR_WIN_W        10
`define WDTR_WIN_RST      10'h000
`define WDTR_SEL_RST      2'h0
`endif

//--- src/wdtr_tap.v
`timescale 1ns/1ns
`include "wdtr_consts.vh"
// ----------------------------------------------------------------
// Timeout tap: one-cycle pulse when count equals 2^exp - 1
// ----------------------------------------------------------------
module wdtr_tap (
  input  wire [`WDTR_CNT_W-1:0] count_i,
  input  wire [1:0]             timeout_select_i,
  output wire                   hit_o
);

  function tap_match;
    input [`WDTR_CNT_W-1:0] c;
    input [1:0]             s;
    reg   [`WDTR_CNT_W-1:0] lim;
    begin
      case (s)
        2'h0:    lim = (25'h0000001 << `WDTR_EXP_SEL0) - 25'h0000001;
        2'h1:    lim = (25'h0000001 << `WDTR_EXP_SEL1) - 25'h0000001;
        2'h2:    lim = (25'h0000001 << `WDTR_EXP_SEL2) - 25'h0000001;
        default: lim = (25'h0000001 << `WDTR_EXP_SEL3) - 25'h0000001;
      endcase
      tap_match = (c == lim);
    end
  endfunction

  assign hit_o = tap_match(count_i, timeout_select_i);

endmodule // wdtr_tap

//--- sim/wdtr_monitor.sv
`timescale 1ns/1ns
module wdtr_monitor (
  input wire       clock_i,
  input wire       resetn_i,
  input wire       enable_i,
  input wire       restart_i,
  input wire       int_enable_i,
  input wire [1:0] timeout_select_i,
  input wire       timeout_irq_o,
  input wire       timeout_flag_o,
  input wire       window_active_o,
  input wire       sys_reset_o
);
  reg  [25:0] c_ff;
  reg  [1:0]  s_ff;
  wire        w = window_active_o, s = sys_reset_o, i = timeout_irq_o;
  wire        k = restart_i | ~enable_i;
  wire [25:0] t = 26'h1 << (15 + 3 * s_ff);
  // Self-restart after a reset pulse: count resumes at one
  always @(posedge clock_i or negedge resetn_i)
    if (!resetn_i) {c_ff, s_ff} <= 28'h0;
    else {c_ff, s_ff} <= {k ? 26'h0 : s ? 26'h1 : c_ff + 26'h1,
                          k ? timeout_select_i : s_ff};
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  a_irq_gate: assert property ($rose(w) |-> i == $past(int_enable_i))
    else $error("gate");
  a_irq_pulse: assert property (i |-> $rose(w) ##1 !i) else $error("p");
  a_rst_pulse: assert property (s |=> !s) else $error("pulse");
  a_rst_end: assert property (s |-> $fell(w)) else $error("end");
  a_win_len: assert property (s |-> c_ff == t + 26'h200)
    else $error("win");
  a_kick_clr: assert property (k |=> !(w | timeout_flag_o))
    else $error("kick");
  a_tmo_len: assert property ($rose(w) |-> c_ff == t) else $error("t");
  a_one_count: assert property ($rose(w) |-> $rose(timeout_flag_o))
    else $error("flag");
  cover property (s);
  cover property (i);
  cover property (w && k);
endmodule // wdtr_monitor
bind wdtr_watchdog wdtr_monitor wdtr_monitor_i (
  .clock_i          (clock_i),
  .resetn_i         (resetn_i),
  .enable_i         (enable_i),
  .restart_i        (restart_i),
  .int_enable_i     (int_enable_i),
  .timeout_select_i (timeout_select_i),
  .timeout_irq_o    (timeout_irq_o),
  .timeout_flag_o   (timeout_flag_o),
  .window_active_o  (window_active_o),
  .sys_reset_o      (sys_reset_o)
);

//--- sim/wdtr_watchdog_tb.sv
`timescale 1ns/1ns
module wdtr_watchdog_tb;
  reg clock_i = 0, resetn_i = 0, enable_i = 1, restart_i = 0, int_enable_i = 1;
  reg [1:0] timeout_select_i = 2'h0;
  wire timeout_irq_o, timeout_flag_o, window_active_o, sys_reset_o;
  int n = 0, c0, err_total = 0, samples_checked = 0, q[$];
  always #20 clock_i = ~clock_i;
  always @(posedge clock_i) n <= n + 1;
  wdtr_watchdog wdtr_watchdog_i (
    .clock_i          (clock_i),
    .resetn_i         (resetn_i),
    .enable_i         (enable_i),
    .restart_i        (restart_i),
    .int_enable_i     (int_enable_i),
    .timeout_select_i (timeout_select_i),
    .timeout_irq_o    (timeout_irq_o),
    .timeout_flag_o   (timeout_flag_o),
    .window_active_o  (window_active_o),
    .sys_reset_o      (sys_reset_o)
  );
  task chk(input logic [31:0] v, e);
    samples_checked++;
    err_total += v !== e;
    if (v !== e) $display("mismatch %0t got %0h exp %0h", $time, v, e);
  endtask
  task test_done;
    $display("%0d checks %0d errors", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task kick(input bit b);
    @(negedge clock_i) {enable_i, restart_i} = b ? 2'h0 : 2'h3;
    @(negedge clock_i) {enable_i, restart_i} = 2'h2;
    c0 = 2 * n;
  endtask
  always @(posedge clock_i) #1 if ((timeout_irq_o | sys_reset_o) === 1'b1)
    chk({n[30:0], sys_reset_o}, q.size() ? q.pop_front() : 0);
  initial begin
    void'($urandom(27412));
    #160 resetn_i = 1;
    kick(0);
    q = '{c0 + 65536, c0 + 66561};
    repeat (33300) @(negedge clock_i);
    int_enable_i = 1'($urandom);
    kick(1);
    timeout_select_i = 2'($urandom);
    if (int_enable_i) q.push_back(c0 + 65536);
    repeat (32770 + $urandom % 500) @(negedge clock_i);
    chk({timeout_flag_o, window_active_o}, 2'h3);
    kick(1);
    chk({timeout_flag_o, window_active_o}, 2'h0);
    repeat (600) @(negedge clock_i);
    chk(q.size(), 0);
    $display("test done");
    test_done;
  end
endmodule // wdtr_watchdog_tb
